// ---- rtl/audio_mailbox_consts.vh ----
`ifndef AUDIO_MAILBOX_CONSTS_VH
`define AUDIO_MAILBOX_CONSTS_VH
// register offsets
`define OFS_HOST_CODE      8'h50
`define OFS_DEV_CODE       8'h58
`define OFS_BACKUP         8'h61
`define OFS_CTRL           8'h70
`define OFS_MASK           8'h71
`define OFS_SERCFG         8'h72
`define OFS_STATUS         8'h75
// interrupt codes
`define CODE_CMP_REQ       8'h24
`define CODE_UNC_REQ       8'h02
`define CODE_READY         8'h05
`define CODE_DONE_A        8'hc0
`define CODE_DONE_B        8'h80
`define CODE_UNC_ACK       8'h03
`define CODE_FINISH        8'h04
// control register fields
`define CTRL_ISEL_LSB      0
`define CTRL_PASS16K_BIT   2
`define CTRL_INBAND_BIT    3
`define CTRL_RATE16K_BIT   4
`define ISEL_HOST_HOST     2'h0
`define ISEL_SERIAL_HOST   2'h1
// status register fields
`define STAT_DSP_IRQ_INDICATOR_BIT      0
`define STAT_HOST_IRQ_PENDING_BIT_BIT      1
`define STAT_BUSY_BIT      2
// reset values
`define CTRL_RESET         8'h00
`define MASK_RESET         8'h01
`define CODE_RESET         8'h00
// serial default: bit0 terminal mode, bit1 double clock, bits3:2 channels one/two, bit4 16 bit
`define SERCFG_DEFAULT     8'h17
// byte counts
`define PT_FIRST_BYTES     9'h100
`define PT_SECOND_OUTBAND  9'h040
`define PT_SECOND_INBAND   9'h050
`define UNC_BYTES_8K       9'h028
`define UNC_BYTES_16K      9'h050
`define FRAME_SAMPLES_8K   8'h50
`define FRAME_SAMPLES_16K  8'ha0
`define UNC_PACKETS        3'h4
// timing
`define MCLK_KHZ           40000
`define INIT_TIME_MS       10
`define INIT_CYCLES        (`INIT_TIME_MS * `MCLK_KHZ)
`endif

// ---- rtl/tx_fifo.v ----
`default_nettype none
module tx_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_q;
    reg [AW-1:0]    rdPtr_q;
    reg [AW:0]      count_q;
    reg             notFull_q;
    reg             notEmpty_q;
    reg [WIDTH-1:0] head_q;
    wire            push = inValid & notFull_q;
    wire            pop  = outReady & notEmpty_q;
    wire [AW:0]     countD = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    wire [AW-1:0]   rdNext = rdPtr_q + {{(AW-1){1'b0}}, pop};

    assign inReady  = notFull_q;
    assign outValid = notEmpty_q;
    assign outData  = head_q;

    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // head register keeps read data off the array output
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q    <= {AW{1'b0}};
            rdPtr_q    <= {AW{1'b0}};
            count_q    <= {(AW+1){1'b0}};
            notFull_q  <= 1'b1;
            notEmpty_q <= 1'b0;
            head_q     <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            rdPtr_q    <= rdNext;
            count_q    <= countD;
            notFull_q  <= (countD != DEPTH[AW:0]);
            notEmpty_q <= (countD != {(AW+1){1'b0}});
            if (push && (countD == {{AW{1'b0}}, 1'b1})) begin
                head_q <= inData;
            end else begin
                head_q <= mem[rdNext];
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/audio_mailbox_handshake.v ----
// Notes on behaviour
// RULE_01 - compressed exchange once per frame; twice in 16k pass-through: 256 then 64/80
// RULE_02 - uncompressed exchange carries 2.5 ms, 20 or 40 samples, four per frame
// RULE_03 - device fills mailbox with encoded frame, msb first, before completion
// RULE_04 - completion: code c0/80 alternating into register 58 and line asserted
// RULE_05 - host reads mailbox; clearing device pending bit is optional
// RULE_06 - host writes decoder frame then code 24 into register 50
// RULE_07 - on code 24 device reads compressed data then clears host pending bit
// RULE_08 - per uncompressed exchange device writes packet then code 03 and line
// RULE_09 - code 03 acknowledges previous host request and requests current exchange
// RULE_10 - host reads packet, writes its packet, then code 02; device reads it
// RULE_11 - after fourth exchange device writes code 04 into register 50 with line
// RULE_12 - host may issue unlimited other requests before host-ready
// RULE_13 - host-ready code 05: device clears host pending bit, starts next frame
// RULE_14 - after setup device waits for code 05 before the first frame
// RULE_15 - status bit shows pending device interrupt regardless of mask
// RULE_16 - select 01 reloads default serial configuration within 10 ms
// RULE_17 - serial default: terminal mode, double clock, channels one/two, 16 bit
// RULE_18 - host may overwrite serial configuration after initialization
// RULE_19 - serial mode paces compressed exchange from sample rate, once or twice
// RULE_20 - serial mode copies completion code into register 61 before raising it; here 61 and 58 load in the same cycle
// RULE_21 - select 00 places both audio streams on the host port
// RULE_22 - code 24 serviced within 125 us, no separate acknowledge interrupt
// RULE_23 - mailbox touched only by the side currently owning it
`include "audio_mailbox_consts.vh"
`default_nettype none
module audio_mailbox_handshake #(
    parameter        FIFO_DEPTH  = 8,
    parameter [31:0] INIT_CYCLES = `INIT_CYCLES
) (
    input  wire       mclk,
    input  wire       rst,
    input  wire       hostWr,
    input  wire       hostRd,
    input  wire [7:0] hostAddr,
    input  wire [7:0] hostWrData,
    output wire [7:0] hostRdData,
    output wire       irqN,
    input  wire [7:0] txData,
    input  wire       txValid,
    output wire       txReady,
    input  wire [8:0] cmpLen,
    input  wire       sampleTick,
    output wire       mbWrEn,
    output wire [8:0] mbWrAddr,
    output wire [7:0] mbWrData,
    output wire       mbRdEn,
    output wire [8:0] mbRdAddr,
    input  wire [7:0] mbRdData,
    output wire [7:0] rxData,
    output wire       rxValid,
    output wire [7:0] serCfg
);
    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_CWR   = 4'h1;
    localparam [3:0] S_CIRQ  = 4'h2;
    localparam [3:0] S_CWAIT = 4'h3;
    localparam [3:0] S_CRD   = 4'h4;
    localparam [3:0] S_UWR   = 4'h5;
    localparam [3:0] S_UIRQ  = 4'h6;
    localparam [3:0] S_UWAIT = 4'h7;
    localparam [3:0] S_URD   = 4'h8;
    localparam [3:0] S_FIN   = 4'h9;
    localparam [3:0] S_RDY   = 4'ha;

    // host strobes and buses are asynchronous pins: three-stage synchronisers
    reg [17:0] pinS1_q;
    reg [17:0] pinS2_q;
    reg [17:0] pinS3_q;
    reg        wrLvl_q;
    reg        rdLvl_q;
    wire       wrAgree = (pinS2_q[17] == pinS3_q[17]);
    wire       rdAgree = (pinS2_q[16] == pinS3_q[16]);
    wire       wrEvt = wrAgree & pinS3_q[17] & ~wrLvl_q;
    wire       rdEvt = rdAgree & pinS3_q[16] & ~rdLvl_q;
    wire [7:0] regAddr = pinS3_q[15:8];
    wire [7:0] regData = pinS3_q[7:0];

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinS1_q <= 18'h00000;
            pinS2_q <= 18'h00000;
            pinS3_q <= 18'h00000;
            wrLvl_q <= 1'b0;
            rdLvl_q <= 1'b0;
        end else begin
            pinS1_q <= {hostWr, hostRd, hostAddr, hostWrData};
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            if (wrAgree) begin
                wrLvl_q <= pinS3_q[17];
            end
            if (rdAgree) begin
                rdLvl_q <= pinS3_q[16];
            end
        end
    end

    reg  [3:0]  state_q;
    reg  [7:0]  ctrl_q;
    reg  [7:0]  mask_q;
    reg  [7:0]  serCfg_q;
    reg  [7:0]  hostCode_q;
    reg  [7:0]  devCode_q;
    reg  [7:0]  backup_q;
    reg         device_irq_pending_bit_q;
    reg         host_irq_pending_bit_q;
    reg         toggle_q;
    reg         run_q;
    reg  [2:0]  uncCnt_q;
    reg  [8:0]  byteCnt_q;
    reg         rdPend_q;
    reg  [31:0] initCnt_q;
    reg  [7:0]  sampCnt_q;
    reg  [7:0]  hostRdData_q;
    reg         irqN_q;
    reg         mbWrEn_q;
    reg  [8:0]  mbWrAddr_q;
    reg  [7:0]  mbWrData_q;
    reg         mbRdEn_q;
    reg  [8:0]  mbRdAddr_q;
    reg  [7:0]  rxData_q;
    reg         rxValid_q;

    wire [1:0]  isel    = ctrl_q[`CTRL_ISEL_LSB+1:`CTRL_ISEL_LSB];
    wire        pass16k = ctrl_q[`CTRL_PASS16K_BIT];
    wire        inband  = ctrl_q[`CTRL_INBAND_BIT];
    wire        rate16k = ctrl_q[`CTRL_RATE16K_BIT];
    wire        hostHost = (isel == `ISEL_HOST_HOST);
    wire        serHost  = (isel == `ISEL_SERIAL_HOST);
    wire        initBusy = (initCnt_q != 32'h00000000);

    // byte count of the current run
    reg  [8:0]  runLen;
    always @* begin
        if (state_q == S_UWR || state_q == S_URD) begin
            runLen = rate16k ? `UNC_BYTES_16K : `UNC_BYTES_8K;                 // [RULE_02]
        end else if (pass16k) begin
            if (!run_q) begin
                runLen = `PT_FIRST_BYTES;                                       // [RULE_01]
            end else begin
                runLen = inband ? `PT_SECOND_INBAND : `PT_SECOND_OUTBAND;      // [RULE_01]
            end
        end else begin
            runLen = cmpLen;
        end
    end

    wire        wrPhase  = (state_q == S_CWR) || (state_q == S_UWR);
    wire        rdPhase  = (state_q == S_CRD) || (state_q == S_URD);
    wire        wrMore   = wrPhase && (byteCnt_q != runLen);
    wire [7:0]  fifoData;
    wire        fifoValid;
    // mailbox is written only while the device owns it
    wire        fifoPop  = wrMore && fifoValid;                                // [RULE_23]
    wire        wrDone   = wrPhase && (byteCnt_q == runLen);
    wire        rdIssue  = rdPhase && (byteCnt_q != runLen);
    wire        rdDone   = rdPhase && (byteCnt_q == runLen) && !rdPend_q;
    wire        hostReq  = host_irq_pending_bit_q;

    // serial mode pacing: frame starts at sample wrap, second run at half frame
    wire [7:0]  frameSamp = rate16k ? `FRAME_SAMPLES_16K : `FRAME_SAMPLES_8K;
    wire        frameWrap = sampleTick && (sampCnt_q == frameSamp - 8'h01);
    wire        halfMark  = sampleTick && (sampCnt_q == {1'b0, frameSamp[7:1]} - 8'h01);

    tx_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) uFifo (
        .clk      (mclk),
        .rst      (rst),
        .inData   (txData),
        .inValid  (txValid),
        .inReady  (txReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q    <= S_IDLE;
            ctrl_q     <= `CTRL_RESET;
            mask_q     <= `MASK_RESET;
            serCfg_q   <= `SERCFG_DEFAULT;
            hostCode_q <= `CODE_RESET;
            devCode_q  <= `CODE_RESET;
            backup_q   <= `CODE_RESET;
            device_irq_pending_bit_q     <= 1'b0;
            host_irq_pending_bit_q     <= 1'b0;
            toggle_q   <= 1'b0;
            run_q      <= 1'b0;
            uncCnt_q   <= 3'h0;
            byteCnt_q  <= 9'h000;
            rdPend_q   <= 1'b0;
            initCnt_q  <= 32'h00000000;
            sampCnt_q  <= 8'h00;
            mbWrEn_q   <= 1'b0;
            mbWrAddr_q <= 9'h000;
            mbWrData_q <= 8'h00;
            mbRdEn_q   <= 1'b0;
            mbRdAddr_q <= 9'h000;
            rxData_q   <= 8'h00;
            rxValid_q  <= 1'b0;
        end else begin
            mbWrEn_q  <= fifoPop;
            mbRdEn_q  <= rdIssue;
            rdPend_q  <= rdIssue;
            rxValid_q <= rdPend_q;
            if (fifoPop) begin
                mbWrData_q <= fifoData;                                        // [RULE_03]
                mbWrAddr_q <= byteCnt_q;
                byteCnt_q  <= byteCnt_q + 9'h001;
            end
            if (rdIssue) begin
                mbRdAddr_q <= byteCnt_q;
                byteCnt_q  <= byteCnt_q + 9'h001;
            end
            if (rdPend_q) begin
                rxData_q <= mbRdData;
            end
            if (initBusy) begin
                initCnt_q <= initCnt_q - 32'h00000001;
            end
            if (sampleTick) begin
                sampCnt_q <= frameWrap ? 8'h00 : sampCnt_q + 8'h01;           // [RULE_19]
            end

            case (state_q)
                S_IDLE: begin
                    byteCnt_q <= 9'h000;
                    if (hostHost) begin
                        state_q <= S_RDY;                                      // [RULE_14] [RULE_21]
                    end else if (serHost && !initBusy && (frameWrap || (pass16k && halfMark))) begin
                        run_q   <= halfMark;                                   // [RULE_19]
                        state_q <= S_CWR;
                    end
                end
                S_CWR: begin
                    if (wrDone) begin
                        state_q <= S_CIRQ;                                     // [RULE_03]
                    end
                end
                S_CIRQ: begin
                    // backup goes out in the same cycle as the code, one cycle ahead of the line, so a slow host can spot a miss
                    if (serHost) begin
                        backup_q <= toggle_q ? `CODE_DONE_B : `CODE_DONE_A;   // [RULE_20]
                    end
                    state_q <= S_CWAIT;
                end
                S_CWAIT: begin
                    byteCnt_q <= 9'h000;
                    if (hostReq && hostCode_q == `CODE_CMP_REQ) begin
                        state_q <= S_CRD;                                      // [RULE_07]
                    end
                end
                S_CRD: begin
                    if (rdDone) begin
                        byteCnt_q <= 9'h000;
                        // no acknowledge interrupt: the cleared pending bit is the answer
                        uncCnt_q  <= 3'h0;                                     // [RULE_22]
                        if (serHost) begin
                            state_q <= S_IDLE;
                        end else if (pass16k && !run_q) begin
                            run_q   <= 1'b1;                                   // [RULE_01]
                            state_q <= S_CWR;
                        end else begin
                            run_q   <= 1'b0;
                            state_q <= S_UWR;
                        end
                    end
                end
                S_UWR: begin
                    if (wrDone) begin
                        state_q <= S_UIRQ;                                     // [RULE_08]
                    end
                end
                S_UIRQ: begin
                    state_q <= S_UWAIT;                                        // [RULE_09]
                end
                S_UWAIT: begin
                    byteCnt_q <= 9'h000;
                    if (hostReq && hostCode_q == `CODE_UNC_REQ) begin
                        state_q <= S_URD;                                      // [RULE_10]
                    end
                end
                S_URD: begin
                    if (rdDone) begin
                        byteCnt_q <= 9'h000;
                        uncCnt_q  <= uncCnt_q + 3'h1;
                        if (uncCnt_q == `UNC_PACKETS - 3'h1) begin
                            state_q <= S_FIN;                                  // [RULE_02]
                        end else begin
                            state_q <= S_UWR;
                        end
                    end
                end
                S_FIN: begin
                    state_q <= S_RDY;                                          // [RULE_11]
                end
                S_RDY: begin
                    // other host requests may come and go here without limit
                    if (!hostHost) begin
                        state_q <= S_IDLE;                                     // [RULE_12]
                    end else if (hostReq && hostCode_q == `CODE_READY) begin
                        byteCnt_q <= 9'h000;
                        state_q   <= S_CWR;                                    // [RULE_13] [RULE_14]
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase

            // device-side register effects
            if (state_q == S_CRD && rdDone) begin
                host_irq_pending_bit_q <= 1'b0;                                                // [RULE_07]
            end
            if (state_q == S_URD && rdDone) begin
                host_irq_pending_bit_q <= 1'b0;
            end
            if (state_q == S_RDY && hostHost && hostReq && hostCode_q == `CODE_READY) begin
                host_irq_pending_bit_q <= 1'b0;                                                // [RULE_13]
            end
            if (state_q == S_FIN) begin
                hostCode_q <= `CODE_FINISH;                                    // [RULE_11]
            end

            // host writes; a host set of the pending bit wins over the device clear
            if (wrEvt) begin
                case (regAddr)
                    `OFS_HOST_CODE: begin
                        hostCode_q <= regData;                                 // [RULE_06]
                        host_irq_pending_bit_q     <= 1'b1;
                    end
                    `OFS_STATUS: begin
                        if (regData[`STAT_DSP_IRQ_INDICATOR_BIT]) begin
                            device_irq_pending_bit_q <= 1'b0;                                    // [RULE_05]
                        end
                    end
                    `OFS_CTRL: begin
                        ctrl_q <= regData;
                        if (regData[1:0] == `ISEL_SERIAL_HOST && isel != `ISEL_SERIAL_HOST) begin
                            serCfg_q  <= `SERCFG_DEFAULT;                      // [RULE_16] [RULE_17]
                            initCnt_q <= INIT_CYCLES;                          // [RULE_16]
                            sampCnt_q <= 8'h00;
                        end
                    end
                    `OFS_MASK: begin
                        mask_q <= regData;
                    end
                    `OFS_SERCFG: begin
                        if (!initBusy) begin
                            serCfg_q <= regData;                               // [RULE_18]
                        end
                    end
                    default: begin
                        mask_q <= mask_q;
                    end
                endcase
            end

            // device raises after the host clear so its set always wins
            if (state_q == S_CIRQ) begin
                devCode_q <= toggle_q ? `CODE_DONE_B : `CODE_DONE_A;          // [RULE_04]
                toggle_q  <= ~toggle_q;                                        // [RULE_04]
                device_irq_pending_bit_q    <= 1'b1;
            end
            if (state_q == S_UIRQ) begin
                devCode_q <= `CODE_UNC_ACK;                                    // [RULE_08] [RULE_09]
                device_irq_pending_bit_q    <= 1'b1;
            end
            if (state_q == S_FIN) begin
                device_irq_pending_bit_q <= 1'b1;                                                // [RULE_11]
            end
        end
    end

    // read path and interrupt line, both registered
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            hostRdData_q <= 8'h00;
            irqN_q       <= 1'b1;
        end else begin
            irqN_q <= ~(device_irq_pending_bit_q & mask_q[0]);                                   // [RULE_15]
            if (rdEvt) begin
                case (regAddr)
                    `OFS_HOST_CODE: hostRdData_q <= hostCode_q;
                    `OFS_DEV_CODE:  hostRdData_q <= devCode_q;
                    `OFS_BACKUP:    hostRdData_q <= backup_q;
                    `OFS_CTRL:      hostRdData_q <= ctrl_q;
                    `OFS_MASK:      hostRdData_q <= mask_q;
                    `OFS_SERCFG:    hostRdData_q <= serCfg_q;
                    `OFS_STATUS:    hostRdData_q <= {5'h00, initBusy, host_irq_pending_bit_q, device_irq_pending_bit_q}; // [RULE_15]
                    default:        hostRdData_q <= 8'h00;
                endcase
            end
        end
    end

    assign hostRdData = hostRdData_q;
    assign irqN       = irqN_q;
    assign mbWrEn     = mbWrEn_q;
    assign mbWrAddr   = mbWrAddr_q;
    assign mbWrData   = mbWrData_q;
    assign mbRdEn     = mbRdEn_q;
    assign mbRdAddr   = mbRdAddr_q;
    assign rxData     = rxData_q;
    assign rxValid    = rxValid_q;
    assign serCfg     = serCfg_q;
endmodule
`default_nettype wire

// ---- test/amh_props.sv ----
`default_nettype none
module amh_props (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       irqN,
    input wire logic       mbWrEn,
    input wire logic [8:0] mbWrAddr,
    input wire logic       mbRdEn,
    input wire logic [8:0] mbRdAddr,
    input wire logic [7:0] mbRdData,
    input wire logic [7:0] rxData,
    input wire logic       rxValid,
    input wire logic [7:0] serCfg
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_wr_order: assert property (
        mbWrEn && $past(mbWrEn) |-> mbWrAddr == $past(mbWrAddr) + 9'h1)
        else $error("mailbox write address skipped");
    a_rd_order: assert property (
        mbRdEn && $past(mbRdEn) |-> mbRdAddr == $past(mbRdAddr) + 9'h1)
        else $error("mailbox read address skipped");
    a_wr_range: assert property (mbWrEn |-> mbWrAddr < 9'h100)
        else $error("mailbox write beyond run");
    a_rx_follow: assert property (rxValid |-> $past(mbRdEn))
        else $error("rx byte without read");
    a_rx_data: assert property (rxValid |-> rxData == $past(mbRdData))
        else $error("rx byte differs from mailbox");
    a_one_owner: assert property (!(mbWrEn && mbRdEn))
        else $error("mailbox written and read together");
    a_ser_default: assert property ($past(rst) |-> serCfg == 8'h17)
        else $error("serial default wrong");
    a_irq_quiet: assert property ($past(rst) |-> irqN)
        else $error("interrupt right after reset");
endmodule
bind audio_mailbox_handshake amh_props u_props (.mclk, .rst, .irqN, .mbWrEn, .mbWrAddr,
    .mbRdEn, .mbRdAddr, .mbRdData, .rxData, .rxValid, .serCfg);
`default_nettype wire

// ---- test/mbox_model.sv ----
`default_nettype none
module mbox_model (
    input  wire logic       mclk,
    input  wire logic       wrEn,
    input  wire logic [8:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic       rdEn,
    input  wire logic [8:0] rdAddr,
    output var  logic [7:0] rdData
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:511];
    // read data follows the address at once; inverse outside a read so stale data never passes
    always_comb rdData = rdEn ? mem[rdAddr] : ~mem[rdAddr];
    always @(posedge mclk) begin
        if (wrEn) mem[wrAddr] <= wrData;
    end
endmodule
`default_nettype wire

// ---- test/audio_mailbox_handshake_tb.sv ----
`default_nettype none
module audio_mailbox_handshake_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk = 0, rst = 1, hostWr = 0, hostRd = 0, txValid = 0, maskOn = 1;
    logic [7:0] hostAddr = 0, hostWrData = 0, txData = 0;
    logic       sampleTick = 0;
    logic [7:0] hostRdData, rxData, mbWrData, mbRdData, serCfg;
    logic       irqN, txReady, mbWrEn, mbRdEn, rxValid;
    logic [8:0] mbWrAddr, mbRdAddr;
    logic [7:0] expW [$], expR [$];
    int         n_fail = 0, cmp_count = 0, cyc = 0, wrCnt = 0, seed = 5922, f, k;
    always #12.5 mclk = ~mclk;
    audio_mailbox_handshake #(.INIT_CYCLES(32'd20)) dut (.mclk, .rst, .hostWr, .hostRd,
        .hostAddr, .hostWrData, .hostRdData, .irqN, .txData, .txValid, .txReady,
        .cmpLen(9'h006), .sampleTick, .mbWrEn, .mbWrAddr, .mbWrData, .mbRdEn,
        .mbRdAddr, .mbRdData, .rxData, .rxValid, .serCfg);
    mbox_model mb (.mclk, .wrEn(mbWrEn), .wrAddr(mbWrAddr), .wrData(mbWrData),
        .rdEn(mbRdEn), .rdAddr(mbRdAddr), .rdData(mbRdData));
    task wrap_up;
        $display("compares %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %0t saw %h expected %h", $time, s, e);
        end
    endtask
    always @(negedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            wrap_up;
        end
        if (mbWrEn === 1'b1) begin
            wrCnt++;
            chk(mbWrData, expW.pop_front());
        end
        if (rxValid === 1'b1) chk(rxData, expR.pop_front());
    end
    // strobes held 6 cycles so the 3-stage sync always catches them
    task hw(input logic [7:0] a, input logic [7:0] d);
        hostAddr = a; hostWrData = d; hostWr = 1;
        repeat (6) @(posedge mclk);
        #1 hostWr = 0;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    task hr(input logic [7:0] a, input logic [7:0] e);
        hostAddr = a; hostRd = 1;
        repeat (6) @(posedge mclk);
        #1 hostRd = 0;
        repeat (6) @(posedge mclk);
        #1 chk(hostRdData, e);
    endtask
    task push(input int n);
        repeat (n) begin
            txData = $random(seed); txValid = 1;
            while (txReady !== 1'b1) begin @(posedge mclk); #1; end
            expW.push_back(txData);
            @(posedge mclk);
            #1;
        end
        txValid = 0;
    endtask
    task xchg(input int len, input logic [7:0] code, input logic [7:0] hc, input bit last);
        int i;
        i = 0;
        while (wrCnt < len && i < 3000) begin @(posedge mclk); i++; end
        repeat (10) @(posedge mclk);
        #1 chk(8'(wrCnt), 8'(len));
        wrCnt = 0;
        hr(8'h58, code);
        hr(8'h75, 8'h01);
        chk(irqN, !maskOn);
        if (maskOn) hw(8'h75, 8'h01); // pending left set on the masked frame
        for (i = 0; i < len; i++) begin
            mb.mem[i] = $random(seed);
            expR.push_back(mb.mem[i]);
        end
        hw(8'h50, hc);
        i = 0;
        while (expR.size() > 0 && i < 3000) begin @(posedge mclk); i++; end
        repeat (5) @(posedge mclk);
        // finishing step raises the device pending bit again
        #1 hr(8'h75, (maskOn && !last) ? 8'h00 : 8'h01);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        #1 rst = 0;
        hw(8'h72, 8'h00);
        chk(serCfg, 8'h00);
        hw(8'h70, 8'h00);
        hr(8'h33, 8'h00);
        push(8);
        @(posedge mclk);
        #1 chk(txReady, 1'b0);
        repeat (40) @(posedge mclk);
        #1 chk(irqN, 1'b1);
        chk(8'(wrCnt), 8'h00);
        fork push(820); join_none
        for (f = 0; f < 3; f++) begin
            maskOn = (f == 0);
            if (f == 1) hw(8'h71, 8'h00);
            if (f == 2) hw(8'h70, 8'h0c); // pass-through with inband control
            hw(8'h50, 8'h05);
            xchg(f == 2 ? 256 : 6, f == 1 ? 8'h80 : 8'hc0, 8'h24, 0);
            if (f == 2) xchg(80, 8'h80, 8'h24, 0);
            for (k = 0; k < 4; k++)
                xchg(40, 8'h03, 8'h02, k == 3);
            repeat (20) @(posedge mclk);
            #1 hr(8'h50, 8'h04);
            hr(8'h72, 8'h00);
        end
        chk(8'(expW.size()), 8'h00);
        hw(8'h70, 8'h01);
        hr(8'h75, 8'h05); // still initialising
        repeat (30) @(posedge mclk);
        #1 chk(serCfg, 8'h17);
        push(6);
        repeat (80) begin
            sampleTick = $random(seed) | 1;
            @(posedge mclk);
            #1 sampleTick = 0;
            @(posedge mclk);
            #1;
        end
        xchg(6, 8'hc0, 8'h24, 0);
        hr(8'h61, 8'hc0);
        chk(8'(expR.size() + expW.size()), 8'h00);
        wrap_up;
    end
endmodule
`default_nettype wire
